// File: rtl/chop_detect_pkg.sv
// chop and current-detect configuration: offsets, reset values, field layout, carriers
// assumes a 16-bit register port with 4-bit word addresses
package chop_detect_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CHANNELS = 4;
  localparam int SAMPLE_W = 24;

  //////////////////////////////////////////////////////////////////////////////
  // register offsets (word addresses)
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_RESERVED = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_CONFIG = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_TH_HIGH = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_TH_LOW = 4'h8;

  // reset values
  localparam logic [DATA_W-1:0] RESERVED_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] CONFIG_RESET = 16'h0600;
  localparam logic [DATA_W-1:0] TH_HIGH_RESET = 16'h0000;
  localparam logic [7:0] TH_LOW_RESET = 8'h00;
  localparam logic [3:0] DC_BLOCK_RESET = 4'h0;

  // field positions in the threshold-low word and status word
  localparam int TH_LOW_LSB = 8;
  localparam int DC_BLOCK_LSB = 0;
  localparam int STATUS_DETECTED = 0;
  localparam int STATUS_SETTLING = 1;

  // counter widths
  localparam int SETTLE_W = 17;
  localparam int WINDOW_W = 12;
  localparam int HITS_W = 9;

  // measurement window length in conversion periods, by code
  localparam logic [WINDOW_W-1:0] WINDOW_LEN [8] = '{
    12'h080, 12'h100, 12'h200, 12'h300, 12'h500, 12'h700, 12'hA00, 12'hE00
  };

  //////////////////////////////////////////////////////////////////////////////
  // configuration word layout, msb first
  typedef struct packed {
    logic [2:0] reserved;
    logic [3:0] chop_settle_delay;
    logic chop_on;
    logic detect_every_channel;
    logic [2:0] detect_exceed_count;
    logic [2:0] detect_window_length;
    logic detect_mode_on;
  } config_type;

  // one conversion result for every channel
  typedef struct packed {
    logic valid;
    logic [CHANNELS-1:0][SAMPLE_W-1:0] data;
  } sample_type;

  // magnitude of a two's complement result; full negative scale still fits
  function automatic logic [SAMPLE_W-1:0] magnitude(input logic [SAMPLE_W-1:0] value);
    magnitude = value[SAMPLE_W-1] ? SAMPLE_W'(~value + 1'b1) : value;
  endfunction : magnitude

  // settle length in modulator periods: 2^(code+1)
  function automatic logic [SETTLE_W-1:0] settle_len(input logic [3:0] code);
    settle_len = SETTLE_W'(1) << (code + 5'h01);
  endfunction : settle_len

endpackage : chop_detect_pkg

// File: rtl/chop_settle_timer.sv
// chop settle timer: counts modulator periods before a chopped measurement
// assumes mod_tick is a one-cycle enable at the modulator rate
`timescale 1ns/10ps
`default_nettype none
module chop_settle_timer import chop_detect_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic mod_tick,
  input wire logic [3:0] delay_code,
  // status
  output logic busy,
  output logic done
);

  logic [SETTLE_W-1:0] remaining;
  logic [SETTLE_W-1:0] next_remaining;
  logic next_busy;
  logic next_done;

  // a restart while busy reloads; the earlier measurement is simply abandoned
  always_comb begin
    next_remaining = remaining;
    next_busy = busy;
    next_done = 1'b0;
    if (start) begin
      next_remaining = settle_len(delay_code);
      next_busy = 1'b1;
    end else if (busy && mod_tick) begin
      next_remaining = remaining - SETTLE_W'(1);
      if (remaining == SETTLE_W'(1)) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remaining <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      remaining <= next_remaining;
      busy <= next_busy;
      done <= next_done;
    end
  end

endmodule : chop_settle_timer
`default_nettype wire

// File: rtl/chop_and_current_detect_cfg.sv
// chop and current-detect configuration bank with its settle timer and detector
// assumes a single-cycle register port and results that arrive as one-cycle valid pulses
`timescale 1ns/10ps
`default_nettype none
module chop_and_current_detect_cfg import chop_detect_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rd_data,
  // converter timing and results
  input wire logic mod_tick,
  input wire logic conv_request,
  input wire sample_type sample,
  // measurement control
  output logic measure_start,
  output logic chop_polarity,
  output logic detect_hit
);

  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [DATA_W-1:0] reserved_word;
  config_type cfg;
  logic [DATA_W-1:0] detect_threshold_high;
  logic [7:0] detect_threshold_low;
  logic [3:0] dc_block;
  logic detected;
  logic [DATA_W-1:0] next_reserved_word;
  config_type next_cfg;
  logic [DATA_W-1:0] next_threshold_high;
  logic [7:0] next_threshold_low;
  logic [3:0] next_dc_block;
  logic next_detected;
  logic [DATA_W-1:0] next_rd_data;
  logic settling;
  logic timer_done;

  always_comb begin
    next_reserved_word = reserved_word;
    next_cfg = cfg;
    next_threshold_high = detect_threshold_high;
    next_threshold_low = detect_threshold_low;
    next_dc_block = dc_block;
    next_detected = detected;
    next_rd_data = '0;
    if (wr_en) begin
      unique case (addr)
        OFF_RESERVED: next_reserved_word = wr_data;
        OFF_CONFIG: next_cfg = config_type'(wr_data);
        OFF_TH_HIGH: next_threshold_high = wr_data;
        OFF_TH_LOW: begin
          next_threshold_low = wr_data[TH_LOW_LSB +: 8];
          next_dc_block = wr_data[DC_BLOCK_LSB +: 4];
        end
        OFF_STATUS: if (wr_data[STATUS_DETECTED]) next_detected = 1'b0;
        default: ;
      endcase
    end
    // a detection in the clearing cycle survives
    if (detect_hit) next_detected = 1'b1;
    if (rd_en) begin
      unique case (addr)
        OFF_RESERVED: next_rd_data = reserved_word;
        OFF_CONFIG: next_rd_data = DATA_W'(cfg);
        OFF_TH_HIGH: next_rd_data = detect_threshold_high;
        OFF_TH_LOW: next_rd_data = {detect_threshold_low, 4'h0, dc_block};
        OFF_STATUS: next_rd_data = {14'h0000, settling, detected};
        default: next_rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reserved_word <= RESERVED_RESET;
      cfg <= config_type'(CONFIG_RESET);
      detect_threshold_high <= TH_HIGH_RESET;
      detect_threshold_low <= TH_LOW_RESET;
      dc_block <= DC_BLOCK_RESET;
      detected <= 1'b0;
      rd_data <= '0;
    end else begin
      reserved_word <= next_reserved_word;
      cfg <= next_cfg;
      detect_threshold_high <= next_threshold_high;
      detect_threshold_low <= next_threshold_low;
      dc_block <= next_dc_block;
      detected <= next_detected;
      rd_data <= next_rd_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // global chop: settle before each measurement and flip input polarity
  logic next_measure_start;
  logic next_chop_polarity;

  chop_settle_timer settle_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(conv_request && cfg.chop_on),
    .mod_tick(mod_tick),
    .delay_code(cfg.chop_settle_delay),
    .busy(settling),
    .done(timer_done)
  );

  always_comb begin
    next_chop_polarity = chop_polarity;
    if (cfg.chop_on) begin
      next_measure_start = timer_done;
      if (conv_request) next_chop_polarity = !chop_polarity;
    end else begin
      // without chopping a request starts the measurement at once
      next_measure_start = conv_request;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      measure_start <= 1'b0;
      chop_polarity <= 1'b0;
    end else begin
      measure_start <= next_measure_start;
      chop_polarity <= next_chop_polarity;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // current detect
  logic [SAMPLE_W-1:0] threshold;
  logic [CHANNELS-1:0] exceeds;
  logic trigger;
  logic [HITS_W-1:0] hits_needed;
  logic [HITS_W-1:0] hit_new;
  logic last_in_window;
  logic [WINDOW_W-1:0] win_cnt;
  logic [HITS_W-1:0] hit_cnt;
  logic fired;
  logic [WINDOW_W-1:0] next_win_cnt;
  logic [HITS_W-1:0] next_hit_cnt;
  logic next_fired;
  logic next_detect_hit;

  assign threshold = {detect_threshold_high, detect_threshold_low};

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : gen_compare
      assign exceeds[ch] = magnitude(sample.data[ch]) > threshold;
    end
  endgenerate

  assign trigger = cfg.detect_every_channel ? &exceeds : |exceeds;
  assign hits_needed = HITS_W'(1) << cfg.detect_exceed_count;
  assign hit_new = (hit_cnt == '1) ? hit_cnt : hit_cnt + HITS_W'(trigger);
  assign last_in_window = win_cnt == WINDOW_LEN[cfg.detect_window_length] - 12'h001;

  always_comb begin
    next_win_cnt = win_cnt;
    next_hit_cnt = hit_cnt;
    next_fired = fired;
    next_detect_hit = 1'b0;
    // a configuration write restarts the window so a shorter length takes cleanly
    if (!cfg.detect_mode_on || (wr_en && addr == OFF_CONFIG)) begin
      next_win_cnt = '0;
      next_hit_cnt = '0;
      next_fired = 1'b0;
    end else if (sample.valid) begin
      if (hit_new >= hits_needed && !fired) begin
        next_detect_hit = 1'b1;
        next_fired = 1'b1;
      end
      if (last_in_window) begin
        next_win_cnt = '0;
        next_hit_cnt = '0;
        next_fired = 1'b0;
      end else begin
        next_win_cnt = win_cnt + WINDOW_W'(1);
        next_hit_cnt = hit_new;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt <= '0;
      hit_cnt <= '0;
      fired <= 1'b0;
      detect_hit <= 1'b0;
    end else begin
      win_cnt <= next_win_cnt;
      hit_cnt <= next_hit_cnt;
      fired <= next_fired;
      detect_hit <= next_detect_hit;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [SETTLE_W-1:0] ticks_seen;
  logic [SETTLE_W-1:0] settle_expect;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ticks_seen <= '0;
      settle_expect <= '0;
    end else if (conv_request && cfg.chop_on) begin
      ticks_seen <= '0;
      settle_expect <= settle_len(cfg.chop_settle_delay);
    end else if (settling && mod_tick) begin
      ticks_seen <= ticks_seen + SETTLE_W'(1);
    end
  end

  a_reserved_readback: assert property (
    rd_en && addr == OFF_RESERVED |=> rd_data == $past(reserved_word))
    else $error("reserved word read mismatch");
  a_config_write: assert property (
    (wr_en && addr == OFF_CONFIG) ##1 !(wr_en && addr == OFF_CONFIG) ##1 (rd_en && addr == OFF_CONFIG)
      |=> rd_data == $past(wr_data, 3))
    else $error("config word not stored");
  a_chop_settle_len: assert property (
    timer_done |-> ticks_seen == settle_expect)
    else $error("chop settle length wrong");
  a_chop_off_steady: assert property (
    !cfg.chop_on |=> $stable(chop_polarity) && !timer_done)
    else $error("chopping acted while off");
  a_detect_trigger_mode: assert property (
    detect_hit |-> $past(cfg.detect_mode_on) && $past(sample.valid))
    else $error("detection without enabled mode");
  a_detect_count_met: assert property (
    detect_hit |-> $past(hit_new) >= $past(hits_needed))
    else $error("detection before count reached");
  a_window_bound: assert property (
    cfg.detect_mode_on |-> win_cnt < WINDOW_LEN[cfg.detect_window_length])
    else $error("window counter beyond length");
  a_threshold_low_write: assert property (
    wr_en && addr == OFF_TH_LOW |=> detect_threshold_low == $past(wr_data[15:8]))
    else $error("threshold low byte not stored");
  a_window_restart: assert property (
    cfg.detect_mode_on && sample.valid && last_in_window && !wr_en |=> hit_cnt == '0 && !fired)
    else $error("window did not restart");

  c_chop_measure: cover property (cfg.chop_on && conv_request ##[1:1000] measure_start);
  c_detect_any: cover property (detect_hit && !cfg.detect_every_channel);
  c_detect_every: cover property (detect_hit && cfg.detect_every_channel);
  c_status_clear_race: cover property (detect_hit && wr_en && addr == OFF_STATUS);

endmodule : chop_and_current_detect_cfg
`default_nettype wire

// File: tb/tb_chop_and_current_detect_cfg.sv
// self-checking bench for the chop and current-detect configuration bank
// assumes the bench drives every port directly, no partner model
`timescale 1ns/10ps
`default_nettype none
module tb_chop_and_current_detect_cfg import chop_detect_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wr_data = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic mod_tick = 1'b0;
  logic conv_request = 1'b0;
  sample_type sample = '0;
  logic measure_start;
  logic chop_polarity;
  logic detect_hit;
  int bad_count = 0;
  int n_compared = 0;
  int n_starts = 0;
  int n_hits = 0;
  int cycles = 0;

  chop_and_current_detect_cfg DUT (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .mod_tick(mod_tick),
    .conv_request(conv_request), .sample(sample), .measure_start(measure_start),
    .chop_polarity(chop_polarity), .detect_hit(detect_hit)
  );

  always #10 clk = ~clk;

  // pulses are counted, so checks do not hinge on the exact sampling edge
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (measure_start === 1'b1) n_starts <= n_starts + 1;
    if (detect_hit === 1'b1) n_hits <= n_hits + 1;
    if (cycles == 30000) begin
      bad_count = bad_count + 1;
      final_report();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (bad_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp16

  task automatic cmp_int(input string what, input int exp, input int got);
    n_compared++;
    if (got != exp) begin
      bad_count++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask : cmp_int

  task automatic bus_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask : bus_read

  task automatic pulse_request();
    @(posedge clk);
    conv_request <= 1'b1;
    @(posedge clk);
    conv_request <= 1'b0;
  endtask : pulse_request

  task automatic pulse_tick();
    @(posedge clk);
    mod_tick <= 1'b1;
    @(posedge clk);
    mod_tick <= 1'b0;
  endtask : pulse_tick

  task automatic send(input logic [23:0] d0, d1, d2, d3);
    @(posedge clk);
    sample.valid <= 1'b1;
    sample.data <= {d3, d2, d1, d0};
    @(posedge clk);
    sample.valid <= 1'b0;
  endtask : send

  task automatic hits_are(input string what, input int exp);
    repeat (2) @(posedge clk);
    #1;
    cmp_int(what, exp, n_hits);
  endtask : hits_are

  //////////////////////////////////////////////////////////////////////////////
  task automatic test_registers();
    logic [15:0] d;
    bus_read(OFF_RESERVED, d);
    cmp16("reserved reset", 16'h0000, d);
    bus_read(OFF_CONFIG, d);
    cmp16("config reset", 16'h0600, d);
    @(posedge clk);
    #1;
    cmp16("rd_data after read", 16'h0000, rd_data);
    bus_write(OFF_RESERVED, 16'h0000);
    bus_write(OFF_CONFIG, 16'h1FFF);
    bus_write(OFF_TH_HIGH, 16'hA5C3);
    bus_write(OFF_TH_LOW, 16'h5AFF);
    bus_write(4'hF, 16'hFFFF);
    bus_read(OFF_RESERVED, d);
    cmp16("reserved readback", 16'h0000, d);
    bus_read(OFF_CONFIG, d);
    cmp16("config readback", 16'h1FFF, d);
    bus_read(OFF_TH_HIGH, d);
    cmp16("threshold high", 16'hA5C3, d);
    bus_read(OFF_TH_LOW, d);
    cmp16("threshold low", 16'h5A0F, d);
    bus_read(4'hF, d);
    cmp16("unmapped read", 16'h0000, d);
    // a second reset in mid-run must bring back the defaults
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus_read(OFF_CONFIG, d);
    cmp16("config after reset", 16'h0600, d);
    bus_read(OFF_TH_HIGH, d);
    cmp16("threshold high reset", 16'h0000, d);
  endtask : test_registers

  task automatic test_chop_off();
    int s0;
    s0 = n_starts;
    pulse_request();
    repeat (4) @(posedge clk);
    #1;
    cmp_int("start without chop", s0 + 1, n_starts);
  endtask : test_chop_off

  task automatic test_chop_on(input logic [3:0] code);
    int s0;
    int len;
    logic pol;
    logic [15:0] d;
    len = 1 << (code + 1);
    bus_write(OFF_CONFIG, {3'b000, code, 1'b1, 8'h00});
    bus_read(OFF_CONFIG, d);
    cmp16("chop config", {3'b000, code, 1'b1, 8'h00}, d);
    s0 = n_starts;
    pol = chop_polarity;
    pulse_request();
    @(posedge clk);
    #1;
    cmp16("polarity toggle", {15'h0, ~pol}, {15'h0, chop_polarity});
    bus_read(OFF_STATUS, d);
    cmp16("status settling", 16'h0002, d);
    repeat (len - 1) pulse_tick();
    repeat (4) @(posedge clk);
    #1;
    cmp_int("start before settle", s0, n_starts);
    pulse_tick();
    repeat (4) @(posedge clk);
    #1;
    cmp_int("start after settle", s0 + 1, n_starts);
  endtask : test_chop_on

  task automatic test_detect();
    logic [15:0] d;
    bus_write(OFF_TH_HIGH, 16'h0000);
    bus_write(OFF_TH_LOW, 16'h6400);
    bus_write(OFF_CONFIG, 16'h0010);
    send(24'd500, 24'd500, 24'd500, 24'd500);
    send(24'd500, 24'd500, 24'd500, 24'd500);
    hits_are("mode off", 0);
    bus_write(OFF_CONFIG, 16'h0011);
    send(24'd100, 24'd0, 24'd0, 24'd0);
    send(24'd101, 24'd0, 24'd0, 24'd0);
    hits_are("first exceed", 0);
    send(24'hFFFF9B, 24'd0, 24'd0, 24'd0);
    hits_are("second exceed any", 1);
    bus_read(OFF_STATUS, d);
    cmp16("status detected", 16'h0001, d);
    bus_write(OFF_STATUS, 16'h0001);
    bus_read(OFF_STATUS, d);
    cmp16("status cleared", 16'h0000, d);
    send(24'd101, 24'd0, 24'd0, 24'd0);
    hits_are("one hit per window", 1);
    bus_write(OFF_CONFIG, 16'h0091);
    send(24'd101, 24'd101, 24'd101, 24'd0);
    send(24'd101, 24'd101, 24'd101, 24'd0);
    hits_are("not every channel", 1);
    send(24'd101, 24'd101, 24'd101, 24'd101);
    send(24'd101, 24'd101, 24'd101, 24'd101);
    hits_are("every channel", 2);
  endtask : test_detect

  task automatic test_window();
    // one exceed at the start, the window of 128 closes, then restarts
    bus_write(OFF_CONFIG, 16'h0011);
    send(24'd200, 24'd0, 24'd0, 24'd0);
    repeat (127) send(24'd5, 24'd0, 24'd0, 24'd0);
    send(24'd200, 24'd0, 24'd0, 24'd0);
    hits_are("window restart", 2);
    send(24'd200, 24'd0, 24'd0, 24'd0);
    hits_are("new window hit", 3);
  endtask : test_window

  task automatic test_long_window();
    // four exceeds needed inside a window of 768 results
    bus_write(OFF_CONFIG, 16'h0027);
    repeat (3) send(24'd200, 24'd0, 24'd0, 24'd0);
    hits_are("three of four", 3);
    send(24'd200, 24'd0, 24'd0, 24'd0);
    hits_are("fourth exceed", 4);
    repeat (764) send(24'd5, 24'd0, 24'd0, 24'd0);
    repeat (4) send(24'd200, 24'd0, 24'd0, 24'd0);
    hits_are("long window restart", 5);
  endtask : test_long_window

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    test_registers();
    test_chop_off();
    test_chop_on(4'h0);
    test_chop_on(4'h1);
    test_chop_on(4'h3);
    test_detect();
    test_window();
    test_long_window();
    final_report();
  end
endmodule : tb_chop_and_current_detect_cfg
`default_nettype wire
